/* File: rtl/power_state_cfg_regs.svh */
`ifndef POWER_STATE_CFG_REGS_SVH
`define POWER_STATE_CFG_REGS_SVH

// Timing of one select-pin measurement, in clock cycles except DISCHARGE_TIME_NS, which is in ns.
`define DISCHARGE_TIME_NS 1000
`define DISCHARGE_CYCLES (`DISCHARGE_TIME_NS / 10)
`define CHARGE_LIMIT_CYCLES 16'hFFFF
`define SYNC_CYCLES 16'h0002

// Reset value of the decoded configuration index, and the number of bins.
`define CFG_INDEX_RESET 8'h00
`define BIN_COUNT 16

`endif

/* File: rtl/power_state_cfg_pkg.sv */
package power_state_cfg_pkg;
   typedef enum logic [2:0]
   {
      PWR_RESET = 3'b000,
      PWR_MEASURE = 3'b001,
      PWR_WAIT_INSERT = 3'b010,
      PWR_SINK_DISCOVERY = 3'b011,
      PWR_ACTIVE = 3'b100
   } power_state_type;

   typedef enum logic [1:0]
   {
      MEAS_DISCHARGE = 2'b00,
      MEAS_CHARGE = 2'b01,
      MEAS_DONE = 2'b10
   } meas_state_type;
endpackage

/* File: rtl/rc_bin_if.sv */
`timescale 1ns/1ns
interface rc_bin_if;
   logic start;
   logic done;
   logic [3:0] bin;
   modport owner (output start, input done, input bin);
   modport meter (input start, output done, output bin);
endinterface

/* File: rtl/rc_bin_meter.sv */
`timescale 1ns/1ns
`include "power_state_cfg_regs.svh"
module rc_bin_meter
#(
   parameter logic [15:0] BIN_BOUNDS [15] = '{
      16'h0002, 16'h0004, 16'h0008, 16'h000C, 16'h0014, 16'h0020,
      16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800,
      16'h1000, 16'h2000, 16'h4000}
)
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic pinLevel,
   output logic pinOut,
   output logic pinOutEnable,
   rc_bin_if.meter ctl
);
   power_state_cfg_pkg::meas_state_type state;
   logic [15:0] count;
   logic syncA;
   logic syncB;

   // Same boundaries serve every select pin.
   function automatic logic [3:0] classify(input logic [15:0] t);
      logic [3:0] b;
      b = 4'h0;
      for (int i = 0; i < 15; i++)
      begin
         if (t >= BIN_BOUNDS[i])
         begin
            b = 4'(i + 1);
         end
      end
      return b;
   endfunction

   always_ff @(posedge sys_clk)
   begin
      syncA <= pinLevel;
      syncB <= syncA;
   end

   // Discharge the pin, release it, and time the rise into a bin.
   always_ff @(posedge sys_clk)
   begin
      if (srst || ctl.start)
      begin
         state <= power_state_cfg_pkg::MEAS_DISCHARGE;
         count <= 16'h0000;
         ctl.done <= 1'b0;
         ctl.bin <= 4'h0;
      end
      else
      begin
         case (state)
            power_state_cfg_pkg::MEAS_DISCHARGE:
            begin
               count <= count + 16'h0001;
               if (count == 16'(`DISCHARGE_CYCLES - 1))
               begin
                  count <= 16'h0000;
                  state <= power_state_cfg_pkg::MEAS_CHARGE;
               end
            end
            power_state_cfg_pkg::MEAS_CHARGE:
            begin
               if (syncB || count == `CHARGE_LIMIT_CYCLES)
               begin
                  // The synchroniser delay is taken off the rise time.
                  ctl.bin <= classify((count < `SYNC_CYCLES) ? 16'h0000
                     : count - `SYNC_CYCLES);
                  ctl.done <= 1'b1;
                  state <= power_state_cfg_pkg::MEAS_DONE;
               end
               else
               begin
                  count <= count + 16'h0001;
               end
            end
            power_state_cfg_pkg::MEAS_DONE:
            begin
               state <= power_state_cfg_pkg::MEAS_DONE;
            end
            default:
            begin
               state <= power_state_cfg_pkg::MEAS_DISCHARGE;
            end
         endcase
      end
   end

   assign pinOut = 1'b0;
   assign pinOutEnable = (state == power_state_cfg_pkg::MEAS_DISCHARGE);
endmodule

/* File: rtl/power_state_cfg_select.sv */
`timescale 1ns/1ns
`include "power_state_cfg_regs.svh"
module power_state_cfg_select
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic chipResetN,
   input wire logic supplyAboveUpper,
   input wire logic supplyBelowLower,
   input wire logic config_select_pin_a_in,
   output logic config_select_pin_a_out,
   output logic config_select_pin_a_oe,
   input wire logic config_select_pin_b_in,
   output logic config_select_pin_b_out,
   output logic config_select_pin_b_oe,
   input wire logic cable_attach_sense,
   input wire logic plugInsertSense,
   input wire logic partnerConnected,
   input wire logic vbusPresent,
   output logic systemReset,
   output logic configValid,
   output logic [7:0] configIndex,
   output logic configReserved,
   output logic roleProvider,
   output logic receptacleStdA,
   output logic standby,
   output logic supplyEnable5v,
   output logic discoveryStart,
   output logic captiveCable,
   output logic currentLimit3a
);
   logic [1:0] resetSync;
   logic [1:0] upSync;
   logic [1:0] downSync;
   logic [1:0] attachSync;
   logic [1:0] insertSync;
   logic [1:0] partnerSync;
   logic [1:0] vbusSync;
   logic porActive;
   logic sysRst;
   logic measStarted;
   logic [3:0] binA;
   logic [3:0] binB;
   logic next_standby;
   power_state_cfg_pkg::power_state_type state;
   rc_bin_if chanA ();
   rc_bin_if chanB ();

   always_ff @(posedge sys_clk)
   begin
      resetSync <= {resetSync[0], chipResetN};
      upSync <= {upSync[0], supplyAboveUpper};
      downSync <= {downSync[0], supplyBelowLower};
      attachSync <= {attachSync[0], cable_attach_sense};
      insertSync <= {insertSync[0], plugInsertSense};
      partnerSync <= {partnerSync[0], partnerConnected};
      vbusSync <= {vbusSync[0], vbusPresent};
   end

   // Asserted below the lower threshold, released above the upper.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         porActive <= 1'b1;
      end
      else if (downSync[1])
      begin
         porActive <= 1'b1;
      end
      else if (upSync[1])
      begin
         porActive <= 1'b0;
      end
   end

   assign sysRst = srst || porActive || !resetSync[1];
   assign systemReset = sysRst;

   always_ff @(posedge sys_clk)
   begin
      if (sysRst)
      begin
         measStarted <= 1'b0;
      end
      else
      begin
         measStarted <= 1'b1;
      end
   end

   assign chanA.start = sysRst || !measStarted;
   assign chanB.start = sysRst || !measStarted;

   rc_bin_meter meterA
   (
      .sys_clk(sys_clk),
      .srst(srst),
      .pinLevel(config_select_pin_a_in),
      .pinOut(config_select_pin_a_out),
      .pinOutEnable(config_select_pin_a_oe),
      .ctl(chanA.meter)
   );

   rc_bin_meter meterB
   (
      .sys_clk(sys_clk),
      .srst(srst),
      .pinLevel(config_select_pin_b_in),
      .pinOut(config_select_pin_b_out),
      .pinOutEnable(config_select_pin_b_oe),
      .ctl(chanB.meter)
   );

   assign binA = chanA.bin;
   assign binB = chanB.bin;

   // Decodes the bin pair once and holds it until the next reset.
   always_ff @(posedge sys_clk)
   begin
      if (sysRst)
      begin
         configValid <= 1'b0;
         configIndex <= `CFG_INDEX_RESET;
         configReserved <= 1'b0;
         roleProvider <= 1'b0;
         receptacleStdA <= 1'b0;
      end
      else if (!configValid && chanA.done && chanB.done)
      begin
         configValid <= 1'b1;
         configIndex <= {binB, binA};
         // Pairs beyond the defined set are flagged, not trusted.
         configReserved <= (binB > 4'h1);
         roleProvider <= 1'b1;
         receptacleStdA <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sysRst)
      begin
         captiveCable <= 1'b0;
         currentLimit3a <= 1'b0;
      end
      else
      begin
         captiveCable <= !attachSync[1] && !insertSync[1];
         currentLimit3a <= !attachSync[1] && !insertSync[1];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sysRst)
      begin
         state <= power_state_cfg_pkg::PWR_RESET;
      end
      else
      begin
         case (state)
            power_state_cfg_pkg::PWR_RESET:
            begin
               state <= power_state_cfg_pkg::PWR_MEASURE;
            end
            power_state_cfg_pkg::PWR_MEASURE:
            begin
               if (configValid && roleProvider)
               begin
                  state <= power_state_cfg_pkg::PWR_WAIT_INSERT;
               end
               else if (configValid)
               begin
                  state <= power_state_cfg_pkg::PWR_SINK_DISCOVERY;
               end
            end
            power_state_cfg_pkg::PWR_WAIT_INSERT:
            begin
               // Plug, partner or captive cable ends the low power wait.
               if (insertSync[1] || partnerSync[1] || captiveCable)
               begin
                  state <= power_state_cfg_pkg::PWR_ACTIVE;
               end
            end
            power_state_cfg_pkg::PWR_SINK_DISCOVERY:
            begin
               if (vbusSync[1])
               begin
                  state <= power_state_cfg_pkg::PWR_ACTIVE;
               end
            end
            power_state_cfg_pkg::PWR_ACTIVE:
            begin
               if (roleProvider && !insertSync[1] && !partnerSync[1]
                  && !captiveCable)
               begin
                  state <= power_state_cfg_pkg::PWR_WAIT_INSERT;
               end
               else if (!roleProvider && !vbusSync[1])
               begin
                  state <= power_state_cfg_pkg::PWR_SINK_DISCOVERY;
               end
            end
            default:
            begin
               state <= power_state_cfg_pkg::PWR_RESET;
            end
         endcase
      end
   end

   always_comb
   begin
      next_standby = (state == power_state_cfg_pkg::PWR_WAIT_INSERT)
         || (state == power_state_cfg_pkg::PWR_SINK_DISCOVERY);
   end

   always_ff @(posedge sys_clk)
   begin
      if (sysRst)
      begin
         standby <= 1'b0;
         supplyEnable5v <= 1'b0;
         discoveryStart <= 1'b0;
      end
      else
      begin
         standby <= next_standby;
         supplyEnable5v <= roleProvider
            && (state == power_state_cfg_pkg::PWR_ACTIVE);
         discoveryStart <= roleProvider && supplyEnable5v
            && (state == power_state_cfg_pkg::PWR_ACTIVE);
      end
   end
endmodule

/* File: sim/power_state_cfg_properties.sv */
`timescale 1ns/1ns
`include "power_state_cfg_regs.svh"
module power_state_cfg_properties
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic supplyBelowLower,
   input wire logic config_select_pin_a_oe,
   input wire logic config_select_pin_b_oe,
   input wire logic systemReset,
   input wire logic configValid,
   input wire logic [7:0] configIndex,
   input wire logic configReserved,
   input wire logic standby,
   input wire logic supplyEnable5v,
   input wire logic discoveryStart,
   input wire logic captiveCable,
   input wire logic currentLimit3a
);
   logic [7:0] oeCount;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Counts discharge cycles of select pin a outside system reset.
   // The start cycle after reset adds one to the discharge count.
   always_ff @(posedge sys_clk)
   begin
      oeCount <= (config_select_pin_a_oe && !systemReset) ?
         oeCount + 8'h01 : 8'h00;
   end
   AST_SRST: assert property (disable iff (1'b0) srst |-> systemReset)
      else $error("srst did not raise system reset");
   AST_CLEAR: assert property (systemReset |=>
      !configValid && !supplyEnable5v && !discoveryStart)
      else $error("outputs not cleared by system reset");
   AST_POR: assert property (supplyBelowLower |-> ##[1:4] systemReset)
      else $error("low supply did not raise reset");
   AST_HOLD: assert property (configValid && !systemReset |=>
      configValid && $stable(configIndex))
      else $error("configuration changed without reset");
   AST_RESERVED: assert property (configValid |->
      configReserved == (configIndex[7:4] > 4'h1))
      else $error("reserved flag wrong for bin pair");
   AST_STANDBY: assert property (standby |->
      !supplyEnable5v && !discoveryStart)
      else $error("supply or discovery active in standby");
   AST_WAKE: assert property ($rose(supplyEnable5v) |->
      !standby && !discoveryStart ##1 discoveryStart)
      else $error("discovery not one cycle after supply");
   AST_CAPTIVE: assert property (captiveCable |-> currentLimit3a)
      else $error("captive cable without 3A limit");
   AST_DISCHARGE: assert property ($fell(config_select_pin_a_oe)
      && !systemReset && !$past(systemReset) |->
      oeCount == 8'(`DISCHARGE_CYCLES + 1))
      else $error("discharge length wrong");
   AST_PAIR: assert property ($rose(config_select_pin_a_oe) |->
      $rose(config_select_pin_b_oe))
      else $error("select pins not measured alike");
   COV_RES: cover property (configValid && configReserved);
   COV_CAP: cover property (captiveCable);
   COV_DISC: cover property (discoveryStart);
endmodule
bind power_state_cfg_select power_state_cfg_properties checker_i
(
   .sys_clk, .srst, .supplyBelowLower, .config_select_pin_a_oe,
   .config_select_pin_b_oe, .systemReset, .configValid, .configIndex,
   .configReserved, .standby, .supplyEnable5v, .discoveryStart,
   .captiveCable, .currentLimit3a
);

/* File: sim/rc_net_model.sv */
`timescale 1ns/1ns
module rc_net_model
(
   input wire logic sys_clk,
   input wire logic oe,
   input wire logic [15:0] rise,
   output logic level
);
   logic [15:0] cnt = 16'h0000;
   // Charge time since release; the pin reads high once it reaches rise.
   always_ff @(posedge sys_clk)
   begin
      cnt <= oe ? 16'h0000 : cnt + {15'h0000, cnt != 16'hFFFF};
   end
   assign level = !oe && cnt >= rise;
endmodule

/* File: sim/test_power_state_cfg_select.sv */
`timescale 1ns/1ns
module test_power_state_cfg_select;
   logic sys_clk = 1'b0, srst = 1'b1, chipResetN = 1'b1;
   logic above = 1'b1, below = 1'b0, aOut, aOe, bOut, bOe, aRc, bRc;
   logic attach = 1'b1, plug = 1'b0, partner = 1'b0, vbus = 1'b0;
   logic sysRst, valid, rsv, prov, stdA, stby, sup, disc, capt, lim;
   logic [7:0] idx;
   logic [15:0] riseA = 16'h0000, riseB = 16'h0000;
   int fails = 0, check_count = 0, cycles = 0;
   // Rows: rise of pin a, rise of pin b, expected {bin b, bin a}.
   logic [39:0] rows [4] = '{{16'd26, 16'd3, 8'h15}, {16'd96, 16'd0, 8'h07},
      {16'd10, 16'd0, 8'h03}, {16'd192, 16'd3, 8'h18}};
   wire aIn = aOe ? aOut : aRc;
   wire bIn = bOe ? bOut : bRc;
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         finish_test();
      end
   end
   rc_net_model rc_a_i (.sys_clk(sys_clk), .oe(aOe), .rise(riseA), .level(aRc));
   rc_net_model rc_b_i (.sys_clk(sys_clk), .oe(bOe), .rise(riseB), .level(bRc));
   power_state_cfg_select power_state_cfg_select_i
   (
      .sys_clk(sys_clk), .srst(srst), .chipResetN(chipResetN),
      .supplyAboveUpper(above), .supplyBelowLower(below),
      .config_select_pin_a_in(aIn), .config_select_pin_a_out(aOut),
      .config_select_pin_a_oe(aOe), .config_select_pin_b_in(bIn),
      .config_select_pin_b_out(bOut), .config_select_pin_b_oe(bOe),
      .cable_attach_sense(attach), .plugInsertSense(plug),
      .partnerConnected(partner), .vbusPresent(vbus), .systemReset(sysRst),
      .configValid(valid), .configIndex(idx), .configReserved(rsv),
      .roleProvider(prov), .receptacleStdA(stdA), .standby(stby),
      .supplyEnable5v(sup), .discoveryStart(disc), .captiveCable(capt),
      .currentLimit3a(lim)
   );
   task chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task wait_valid();
      for (int i = 0; i < 800 && valid !== 1'b1; i++) @(negedge sys_clk);
   endtask
   task finish_test();
      $display("comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(negedge sys_clk);
      foreach (rows[i])
      begin
         {riseA, riseB} = rows[i][39:8];
         srst = 1'b1;
         repeat (2) @(negedge sys_clk);
         srst = 1'b0;
         wait_valid();
         chk(idx === rows[i][7:0], "bin pair");
         chk(rsv === (rows[i][7:4] > 4'h1), "reserved");
         chk(prov === 1'b1 && stdA === 1'b1, "role");
         repeat (8) @(negedge sys_clk);
         chk(stby === 1'b1 && sup === 1'b0, "standby");
      end
      riseA = 16'h0000;
      repeat (300) @(negedge sys_clk);
      chk(idx === 8'h18 && valid === 1'b1, "held");
      plug = 1'b1;
      for (int i = 0; i < 10 && sup !== 1'b1; i++) @(negedge sys_clk);
      chk(sup === 1'b1 && stby === 1'b0 && disc === 1'b0, "wake");
      @(negedge sys_clk);
      chk(disc === 1'b1, "discovery");
      chipResetN = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk(sysRst === 1'b1 && valid === 1'b0 && sup === 1'b0, "chip");
      chipResetN = 1'b1;
      {above, below} = 2'b01;
      repeat (4) @(negedge sys_clk);
      {plug, attach, below} = 3'b000;
      repeat (10) @(negedge sys_clk);
      chk(sysRst === 1'b1, "hysteresis");
      above = 1'b1;
      wait_valid();
      repeat (10) @(negedge sys_clk);
      chk(sysRst === 1'b0 && valid === 1'b1, "release");
      chk(capt === 1'b1 && lim === 1'b1, "captive");
      finish_test();
   end
endmodule
